// *** bench/lin_dev_model.sv ***
// Purpose: Behavioural transceiver seen from the host pins
// Assumes: Same clock as the host; bus-state pin has a pull-up
// Notes:   Fault inputs force recessive; i_no_flag omits the rate flag
`timescale 1ns/1ps
module lin_dev_model #(
  parameter int SLEEP_CYC = 7000,
  parameter int WAKE_CYC  = 900,
  parameter int HOLD_CYC  = 4500,
  parameter int DOM_TO    = 500000,
  parameter int FLAG_CYC  = 400,
  parameter int BUS_WAKE_CYC = 7000
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_tx,
  input  wire logic i_en,
  input  wire logic i_wake_sw,
  input  wire logic i_other_dom,
  input  wire logic i_no_flag,
  input  wire logic i_uv,
  input  wire logic i_hot,
  output logic      o_rxd,
  output logic      o_inh,
  output logic      o_bus_dom
);
  typedef enum logic [1:0] {M_NORMAL, M_SLEEP, M_AWAKE} dev_mode_type;
  dev_mode_type mode_q;
  int           lo_cnt, hi_cnt, hold_cnt, dom_cnt, flag_cnt, fall_at, rise_at, bw_cnt;
  logic         fast_q, wake_ref, tx_prev, drv;

  assign drv = (mode_q == M_NORMAL) && i_en && !i_tx && hold_cnt >= HOLD_CYC
               && dom_cnt < DOM_TO
               && !i_uv && !i_hot;
  assign o_bus_dom = drv | i_other_dom;
  // Bus or regulator over-temperature, same response
  assign o_inh = (mode_q != M_SLEEP) && !i_hot;
  // Released pin reads high through the pull-up
  assign o_rxd = (mode_q == M_SLEEP) ? 1'b1 :
                 (mode_q == M_AWAKE) ? 1'b0 :
                 i_hot ? 1'b1 :
                 (flag_cnt == 0) && !o_bus_dom;

  // ----------------------------------------------------------------
  // Mode sequencing, all timed from this clock
  // ----------------------------------------------------------------
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_q <= M_AWAKE;
      {lo_cnt, hi_cnt, hold_cnt, dom_cnt, flag_cnt, fall_at, rise_at, bw_cnt} <= '0;
      {fast_q, wake_ref, tx_prev} <= 3'h1;
    end else begin
      tx_prev <= i_tx;
      lo_cnt <= i_en ? 0 : lo_cnt + 1;
      hi_cnt <= i_en ? hi_cnt + 1 : 0;
      dom_cnt <= i_tx ? 0 : dom_cnt + 1;
      bw_cnt <= (mode_q == M_SLEEP && i_other_dom) ? bw_cnt + 1 : 0;
      if (flag_cnt > 0) flag_cnt <= flag_cnt - 1;
      if (hold_cnt < HOLD_CYC) hold_cnt <= hold_cnt + 1;
      if (!i_en && tx_prev && !i_tx) fall_at <= lo_cnt;
      if (!i_en && !tx_prev && i_tx) rise_at <= lo_cnt;
      if (mode_q == M_NORMAL) begin
        if (i_en && lo_cnt > 0) begin
          if (lo_cnt <= 4500 && fall_at >= 1250 && rise_at - fall_at >= 1250
              && lo_cnt - rise_at >= 1250) begin
            fast_q <= !fast_q;
            if (!fast_q && !i_no_flag) flag_cnt <= FLAG_CYC;
          end
          fall_at <= 0;
          rise_at <= 0;
        end
        if (!i_en && lo_cnt >= SLEEP_CYC) begin
          mode_q <= M_SLEEP;
          wake_ref <= i_wake_sw;
        end
      end else if (hi_cnt > WAKE_CYC) begin
        mode_q <= M_NORMAL;
        hold_cnt <= 0;
      end else if (mode_q == M_SLEEP && i_wake_sw != wake_ref) begin
        mode_q <= M_AWAKE;
      end else if (mode_q == M_SLEEP && !i_other_dom && bw_cnt > BUS_WAKE_CYC) begin
        mode_q <= M_AWAKE;
      end
    end
  end
endmodule : lin_dev_model

// *** bench/tb.sv ***
// Purpose: Self-checking bench for the transceiver host controller
// Assumes: Device model answers on the bus-state pin
// Notes:   Dominant time-out shortened to 50 cycles
`timescale 1ns/1ps
module tb;
  import lin_host_pkg::*;
  logic         i_clk, i_rst, i_rxd, o_rx_data, o_ready, o_fast, o_asleep;
  logic         o_wake_seen, o_flag_err, wake_sw, other_dom, no_flag, regulator_control_output, bus_dom;
  user_req_type i_req;
  xcvr_out_type o_pins;
  logic         uv, hot;
  int           miscompares, checked;

  lin_host_ctrl #(.DOM_TIMEOUT_CYC(50)) u_lin_host_ctrl (.i_clk(i_clk), .i_rst(i_rst),
    .i_req(i_req), .i_rxd(i_rxd), .o_pins(o_pins), .o_rx_data(o_rx_data),
    .o_ready(o_ready), .o_fast(o_fast), .o_asleep(o_asleep),
    .o_wake_seen(o_wake_seen), .o_flag_err(o_flag_err));
  lin_dev_model #(.BUS_WAKE_CYC(20)) u_lin_dev_model (.i_clk(i_clk), .i_rst(i_rst),
    .i_tx(o_pins.tx), .i_en(o_pins.en), .i_wake_sw(wake_sw), .i_other_dom(other_dom),
    .i_no_flag(no_flag), .i_uv(uv), .i_hot(hot), .o_rxd(i_rxd), .o_inh(regulator_control_output),
    .o_bus_dom(bus_dom));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task close_out;
    if (miscompares == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  task chk(input string name, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      $display("mismatch %s expected %b seen %b", name, exp, got);
      miscompares++;
    end
  endtask : chk

  task automatic wait_hi(ref logic s, input int max, input string name);
    int n;
    n = 0;
    while (s !== 1'b1 && n < max) begin
      @(negedge i_clk);
      n++;
    end
    chk(name, 1'b1, s);
  endtask : wait_hi

  task pulse(input logic [2:0] k);
    @(negedge i_clk);
    {i_req.toggle, i_req.sleep, i_req.wake} = k;
    @(negedge i_clk);
    {i_req.toggle, i_req.sleep, i_req.wake} = 3'h0;
    repeat (5) @(negedge i_clk);
  endtask : pulse

  task t_tx_path;
    i_req.tx_data = 1'b0;
    repeat (10) @(negedge i_clk);
    chk("tx", 1'b0, o_pins.tx);
    chk("rx_data", 1'b0, o_rx_data);
    repeat (60) @(negedge i_clk);
    chk("tx_timeout", 1'b1, o_pins.tx);
    i_req.tx_data = 1'b1;
    other_dom = 1'b1;
    repeat (10) @(negedge i_clk);
    chk("rx_other", 1'b0, o_rx_data);
    other_dom = 1'b0;
    repeat (10) @(negedge i_clk);
    chk("rx_idle", 1'b1, o_rx_data);
  endtask : t_tx_path

  task t_fault;
    uv = 1'b1;
    i_req.tx_data = 1'b0;
    repeat (10) @(negedge i_clk);
    chk("bus_uv", 1'b0, bus_dom);
    i_req.tx_data = 1'b1;
    uv = 1'b0;
    hot = 1'b1;
    other_dom = 1'b1;
    repeat (10) @(negedge i_clk);
    chk("inh_hot", 1'b0, regulator_control_output);
    chk("rx_hot", 1'b1, o_rx_data);
    hot = 1'b0;
    other_dom = 1'b0;
    repeat (10) @(negedge i_clk);
    chk("inh_cool", 1'b1, regulator_control_output);
  endtask : t_fault

  task t_toggle(input logic bad, input logic fast, input logic err);
    no_flag = bad;
    pulse(3'h4);
    wait_hi(o_ready, 20000, "ready_toggle");
    chk("flag_err", err, o_flag_err);
    if (!bad) chk("fast", fast, o_fast);
    no_flag = 1'b0;
  endtask : t_toggle

  task t_sleep(input logic by_switch);
    pulse(3'h2);
    wait_hi(o_asleep, 12000, "asleep");
    chk("en_sleep", 1'b0, o_pins.en);
    chk("inh_sleep", 1'b0, regulator_control_output);
    chk("rxd_sleep", 1'b1, i_rxd);
    if (by_switch) begin
      wake_sw = ~wake_sw;
      wait_hi(o_wake_seen, 100, "wake_seen");
    end else begin
      // Bus blip shorter than the wake filter must not wake
      other_dom = 1'b1;
      repeat (10) @(negedge i_clk);
      other_dom = 1'b0;
      repeat (10) @(negedge i_clk);
      chk("wake_clear", 1'b0, o_wake_seen);
      chk("asleep_blip", 1'b1, o_asleep);
    end
    pulse(3'h1);
    wait_hi(o_ready, 20000, "ready_wake");
    chk("asleep_off", 1'b0, o_asleep);
    i_req.tx_data = 1'b0;
    repeat (10) @(negedge i_clk);
    chk("bus_first", 1'b1, bus_dom);
    i_req.tx_data = 1'b1;
  endtask : t_sleep

  initial begin
    // Tests need about 88k cycles
    #950_000;
    miscompares++;
    close_out();
  end

  initial begin
    {i_rst, i_req, wake_sw, other_dom, no_flag} = 8'hC0;
    {uv, hot} = 2'h0;
    miscompares = 0;
    checked = 0;
    repeat (5) @(negedge i_clk);
    i_rst = 1'b0;
    wait_hi(o_ready, 12000, "ready_reset");
    chk("en_reset", 1'b1, o_pins.en);
    t_tx_path();
    t_fault();
    t_toggle(1'b0, 1'b1, 1'b0);
    t_toggle(1'b0, 1'b0, 1'b0);
    t_toggle(1'b1, 1'b1, 1'b1);
    t_sleep(1'b1);
    t_sleep(1'b0);
    close_out();
  end
endmodule : tb

// *** design/lin_host_ctrl.sv ***
// Purpose: Host-side controller driving transmit and control pins of a
//          single-wire transceiver, and reading its bus-state output
// Assumes: Bus-state input idles high via external pull-up while released
// Notes:   Toggle, sleep and wake run as timed sequences on one counter
`timescale 1ns/1ps

module lin_host_ctrl #(
  parameter int DOM_TIMEOUT_CYC = lin_host_pkg::DOM_TO_CYC
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst,
  input  wire lin_host_pkg::user_req_type i_req,
  input  wire logic                       i_rxd,
  output lin_host_pkg::xcvr_out_type      o_pins,
  output logic                            o_rx_data,
  output logic                            o_ready,
  output logic                            o_fast,
  output logic                            o_asleep,
  output logic                            o_wake_seen,
  output logic                            o_flag_err
);
  import lin_host_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    host_state_type st;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] dom;
    logic [CNT_W-1:0] lo_run;
    logic            flag_lo;
    logic            fast;
    logic            wake;
    logic            ferr;
    xcvr_out_type    pins;
  } ctrl_state_type;

  ctrl_state_type s_q, s_d;
  logic [0:0]     rxd_s;

  lin_host_sync #(.W(1)) u_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async (i_rxd),
    .o_sync  (rxd_s)
  );

  localparam logic [CNT_W-1:0] C_STEP  = CNT_W'(STEP_CYC);
  localparam logic [CNT_W-1:0] C_FLAG  = CNT_W'(FLAG_WIN_CYC);
  localparam logic [CNT_W-1:0] C_SLEEP = CNT_W'(SLEEP_CYC);
  localparam logic [CNT_W-1:0] C_WAKE  = CNT_W'(WAKE_FILT_CYC);
  localparam logic [CNT_W-1:0] C_FDOM  = CNT_W'(FIRST_DOM_CYC);
  localparam logic [CNT_W-1:0] C_DOMTO = CNT_W'(DOM_TIMEOUT_CYC);
  localparam logic [CNT_W-1:0] C_ONE   = CNT_W'(1);
  localparam logic [CNT_W-1:0] C_ENLO  = CNT_W'(EN_LOW_CYC);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.cnt = s_q.cnt + C_ONE;
    unique case (s_q.st)
      ST_IDLE: begin
        // Control high, then wait out wake filter (skipped after a toggle) and drive hold-off
        s_d.pins = '{tx: 1'b1, en: 1'b1};
        if (s_q.cnt >= C_WAKE + C_FDOM) begin
          s_d.st = ST_NORMAL;
          s_d.cnt = '0;
        end
      end
      ST_NORMAL: begin
        // Transmit follows user data, cut back after dominant time-out
        if (!i_req.tx_data && s_q.dom < C_DOMTO) begin
          s_d.pins.tx = 1'b0;
          s_d.dom = s_q.dom + C_ONE;
        end else begin
          s_d.pins.tx = 1'b1;
          if (i_req.tx_data) s_d.dom = '0;
        end
        s_d.pins.en = 1'b1;
        if (i_req.toggle) begin
          s_d.pins = '{tx: 1'b1, en: 1'b0};
          s_d.st = ST_TG_ENLO;
          s_d.cnt = '0;
          s_d.dom = '0;
        end else if (i_req.sleep) begin
          s_d.pins = '{tx: 1'b1, en: 1'b0};
          s_d.st = ST_SLEEPGO;
          s_d.cnt = '0;
          s_d.dom = '0;
        end
      end
      ST_TG_ENLO: begin
        if (s_q.cnt >= C_STEP - C_ONE) begin
          s_d.pins.tx = 1'b0;
          s_d.st = ST_TG_TXLO;
          s_d.cnt = '0;
        end
      end
      ST_TG_TXLO: begin
        if (s_q.cnt >= C_STEP - C_ONE) begin
          s_d.pins.tx = 1'b1;
          s_d.st = ST_TG_TXHI;
          s_d.cnt = '0;
        end
      end
      ST_TG_TXHI: begin
        // Raised well inside the 45 us control-low window
        if (s_q.cnt >= C_STEP - C_ONE) begin
          s_d.pins.en = 1'b1;
          s_d.st = ST_TG_FLAG;
          s_d.cnt = '0;
          s_d.flag_lo = 1'b0;
        end
      end
      ST_TG_FLAG: begin
        // Watch for low flag; none expected when leaving fast rate
        if (!rxd_s[0]) s_d.flag_lo = 1'b1;
        if (s_q.cnt >= C_FLAG + C_STEP) begin
          s_d.ferr = (s_q.flag_lo == s_q.fast);
          s_d.fast = !s_q.fast;
          s_d.st = ST_IDLE;
          s_d.cnt = C_WAKE;
        end
      end
      ST_SLEEPGO: begin
        if (s_q.cnt >= C_SLEEP) begin
          s_d.st = ST_SLEEP;
          s_d.cnt = '0;
        end
      end
      ST_SLEEP: begin
        // Output floats; pull-up reads high until a wake drives it low
        if (!rxd_s[0]) s_d.wake = 1'b1;
        if (i_req.wake || !rxd_s[0]) begin
          s_d.pins.en = 1'b1;
          s_d.st = ST_WAKEGO;
          s_d.cnt = '0;
        end
      end
      ST_WAKEGO: begin
        s_d.fast = 1'b0;
        s_d.st = ST_IDLE;
        s_d.cnt = '0;
      end
      default: begin
        s_d.st = ST_IDLE;
        s_d.cnt = '0;
      end
    endcase
    // Control-low run of a toggle; too long a run would drop the rate change
    if (s_d.st inside {ST_TG_ENLO, ST_TG_TXLO, ST_TG_TXHI}) begin
      s_d.lo_run = s_q.lo_run + C_ONE;
    end else begin
      s_d.lo_run = '0;
    end
    if (s_q.st == ST_NORMAL && i_req.toggle) s_d.ferr = 1'b0;
    if (s_q.st == ST_SLEEP && s_d.st == ST_WAKEGO && !rxd_s[0]) s_d.wake = 1'b1;
    else if (s_q.st == ST_NORMAL && i_req.sleep) s_d.wake = 1'b0;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '{st: ST_IDLE, cnt: '0, dom: '0, lo_run: '0, flag_lo: 1'b0, fast: 1'b0,
               wake: 1'b0, ferr: 1'b0, pins: '{tx: 1'b1, en: 1'b0}};
      o_rx_data <= 1'b1;
      o_ready   <= 1'b0;
      o_asleep  <= 1'b0;
    end else begin
      s_q <= s_d;
      o_rx_data <= rxd_s[0];
      o_ready   <= (s_d.st == ST_NORMAL);
      o_asleep  <= (s_d.st == ST_SLEEP);
    end
  end

  assign o_pins      = s_q.pins;
  assign o_fast      = s_q.fast;
  assign o_wake_seen = s_q.wake;
  assign o_flag_err  = s_q.ferr;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence tx_low_step;
    !o_pins.tx [*8];
  endsequence

  a_toggle_tx_fall: assert property (@(posedge i_clk) disable iff (i_rst)
    s_q.st == ST_TG_ENLO && s_d.st == ST_TG_TXLO |=> !o_pins.tx && !o_pins.en)
    else $error("toggle transmit fall wrong");
  a_toggle_tx_low: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(o_pins.tx) && s_q.st == ST_TG_TXLO |-> tx_low_step)
    else $error("toggle transmit low too short");
  a_toggle_en_rise: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_pins.en) && s_q.st == ST_TG_FLAG |-> o_pins.tx && $past(o_pins.tx, 8))
    else $error("transmit not high before control rise");
  a_toggle_window: assert property (@(posedge i_clk) disable iff (i_rst)
    !o_pins.en |-> s_q.lo_run <= C_ENLO)
    else $error("control low too long");
  a_normal_en_high: assert property (@(posedge i_clk) disable iff (i_rst)
    s_q.st == ST_NORMAL |-> o_pins.en)
    else $error("control low in normal");
  a_dom_timeout: assert property (@(posedge i_clk) disable iff (i_rst)
    s_q.dom >= C_DOMTO |=> o_pins.tx)
    else $error("dominant past time-out");
  a_idle_no_drive: assert property (@(posedge i_clk) disable iff (i_rst)
    s_q.st == ST_IDLE |-> o_pins.tx)
    else $error("dominant during hold-off");
  a_sleep_en_low: assert property (@(posedge i_clk) disable iff (i_rst)
    s_q.st == ST_SLEEPGO |-> !o_pins.en ##1 (!o_pins.en || s_q.st == ST_SLEEP))
    else $error("control raised during sleep entry");
endmodule : lin_host_ctrl

// *** design/lin_host_pkg.sv ***
// Purpose: Shared constants and types for the transceiver host controller
// Assumes: 100 MHz clock, all times converted from ns figures
// Notes:   Times are held in ns, cycle counts derived from the clock period
package lin_host_pkg;

  localparam int CLK_PERIOD_NS = 10;

  // ----------------------------------------------------------------
  // Timing figures (ns)
  // ----------------------------------------------------------------
  localparam int TOGGLE_STEP_NS      = 12500;  // Least spacing of toggle steps
  localparam int TOGGLE_EN_LOW_NS    = 45000;  // Longest control-low window
  localparam int RATE_FLAG_MIN_NS    = 1875;   // Rate flag pulse, least
  localparam int RATE_FLAG_MAX_NS    = 6250;   // Rate flag pulse, longest
  localparam int SLEEP_ENTRY_NS      = 70000;  // Sleep entry delay, typical
  localparam int SLEEP_ENTRY_MAX_NS  = 91000;  // Sleep entry delay, longest
  localparam int CTRL_WAKE_FILT_NS   = 15000;  // Control wake filter, longest
  localparam int FIRST_DOM_NS        = 80000;  // Initial drive hold-off, longest
  localparam int DOM_TIMEOUT_NS      = 5000000; // Dominant time-out

  // Least times and the sleep, wake and hold-off waits round up; other longest times round down
  localparam int STEP_CYC      = (TOGGLE_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EN_LOW_CYC    = TOGGLE_EN_LOW_NS / CLK_PERIOD_NS;
  localparam int FLAG_MIN_CYC  = (RATE_FLAG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLAG_WIN_CYC  = RATE_FLAG_MAX_NS / CLK_PERIOD_NS;
  localparam int SLEEP_CYC     = (SLEEP_ENTRY_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_FILT_CYC = (CTRL_WAKE_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FIRST_DOM_CYC = (FIRST_DOM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DOM_TO_CYC    = DOM_TIMEOUT_NS / CLK_PERIOD_NS;

  localparam int CNT_W = 20;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0000,
    ST_NORMAL  = 4'b0001,
    ST_TG_ENLO = 4'b0010,
    ST_TG_TXLO = 4'b0011,
    ST_TG_TXHI = 4'b0100,
    ST_TG_FLAG = 4'b0101,
    ST_SLEEPGO = 4'b0110,
    ST_SLEEP   = 4'b0111,
    ST_WAKEGO  = 4'b1000
  } host_state_type;

  // Pins toward the transceiver
  typedef struct packed {
    logic tx;
    logic en;
  } xcvr_out_type;

  // User requests, one-cycle pulses except tx_data
  typedef struct packed {
    logic tx_data;
    logic toggle;
    logic sleep;
    logic wake;
  } user_req_type;

endpackage : lin_host_pkg

// *** design/lin_host_sync.sv ***
// Purpose: Two-flop synchroniser for pin inputs, one per bit
// Assumes: Inputs are asynchronous to i_clk
// Notes:   First stage is read by the second stage only
`timescale 1ns/1ps
module lin_host_sync #(
  parameter int W = 2
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_q;

  for (genvar g = 0; g < W; g++) begin : g_bit
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        meta_q[g] <= 1'b1;
        o_sync[g] <= 1'b1;
      end else begin
        meta_q[g] <= i_async[g];
        o_sync[g] <= meta_q[g];
      end
    end
  end
endmodule : lin_host_sync
